// [verilog/tpw_top.sv]
// Implementation choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps
// What this block does
// - fast pwm counts up from zero to top, then restarts at zero
// - fast top: fixed 8/9/10 bit, capture or compare a; clear after top
// - fast action 2 clears on match, sets at bottom; action 3 opposite
// - fast overflow flag at top; top source flag in same tick
// - channel compare flag set when counter equals its compare value
// - fixed top widths mask upper bits of compare writes to zero
// - capture top unbuffered; passed top counts on to wrap
// - fast compare a buffered, loaded at top with clear and overflow
// - fast compare zero gives one tick spike; equal top gives constant level
// - fast mode 15 action 1 toggles output a each match
// - phase correct counts up to top, down to zero, top held one tick
// - phase correct non-inverting clears on up match, sets on down match
// - phase correct overflow at bottom; buffers load at top with top flag
// - phase correct non-inverting compare zero holds low, equal top holds high
// - phase correct mode 11 action 1 toggles output a each match
// - compare output shows on the pin only when direction is output
// - ticks are core clock divided by 1, 8, 64, 256 or 1024
// - action zero leaves compare output unchanged on matches
// - reset clears each compare output register
module tpw_top
	import tpw_pkg::*;
#(
	parameter int unsigned CNT_W = 16
)
(
	input wire logic i_core_clk,
	input wire logic i_srst,
	input wire logic [TPW_ADDR_W-1:0] i_addr,
	input wire logic [TPW_DATA_W-1:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [TPW_DATA_W-1:0] o_rdata,
	output logic o_pin_a,
	output logic o_pin_a_oe,
	output logic o_pin_b,
	output logic o_pin_b_oe
);

	if (CNT_W != TPW_DATA_W)
	begin : g_chk
		$error("counter width must match the 16 bit register word");
	end

	// ************************************************************
	// state
	// ************************************************************
	tpw_ctrl_t ctrl_q;
	tpw_flags_t flags_q;
	tpw_flags_t flags_d;
	tpw_flags_t flags_set;
	tpw_flags_t flags_clr;
	tpw_port_t port_q;
	tpw_dir_t dir_q;
	logic [CNT_W-1:0] count_q;
	logic [CNT_W-1:0] cmp_buf_a_q;
	logic [CNT_W-1:0] cmp_buf_b_q;
	logic [CNT_W-1:0] cmp_act_a_q;
	logic [CNT_W-1:0] cmp_act_b_q;
	logic [CNT_W-1:0] cap_top_q;
	logic [TPW_DATA_W-1:0] rdata_d;

	// ************************************************************
	// decode
	// ************************************************************
	tpw_slope_t slope;
	logic [CNT_W-1:0] fixed_top;
	logic [CNT_W-1:0] top;
	logic [CNT_W-1:0] wmask;
	logic at_top;
	logic tick;
	logic load_evt;
	logic ovf_evt;
	logic match_a;
	logic match_b;
	logic oc_a;
	logic oc_b;
	logic wr_ctrl;
	logic wr_count;
	logic wr_cmp_a;
	logic wr_cmp_b;
	logic wr_cap;
	logic wr_flags;
	logic wr_port;

	assign wr_ctrl = i_wr && (i_addr == TPW_OFS_CTRL);
	assign wr_count = i_wr && (i_addr == TPW_OFS_COUNT);
	assign wr_cmp_a = i_wr && (i_addr == TPW_OFS_CMP_A);
	assign wr_cmp_b = i_wr && (i_addr == TPW_OFS_CMP_B);
	assign wr_cap = i_wr && (i_addr == TPW_OFS_CAP_TOP);
	assign wr_flags = i_wr && (i_addr == TPW_OFS_FLAGS);
	assign wr_port = i_wr && (i_addr == TPW_OFS_PORT);

	assign slope = tpw_slope(ctrl_q.mode);
	assign fixed_top = tpw_fixed_top(ctrl_q.mode);

	// top source; capture top is live, compare a top is the loaded copy
	always_comb
	begin
		if (fixed_top != TPW_BOTTOM)
			top = fixed_top;
		else if (tpw_top_is_cap(ctrl_q.mode))
			top = cap_top_q;
		else if (tpw_top_is_cmpa(ctrl_q.mode))
			top = cmp_act_a_q;
		else
			top = TPW_MAX;
	end

	// compare writes lose bits above a fixed top
	assign wmask = (fixed_top != TPW_BOTTOM) ? fixed_top : TPW_MAX;

	assign at_top = (count_q == top);

	// buffer load point: top on the way up, in either pwm slope
	assign load_evt = tick && at_top && ((slope == TPW_SLOPE_SINGLE)
		|| (slope == TPW_SLOPE_DUAL && dir_q == TPW_DIR_UP));

	// overflow point per slope
	always_comb
	begin
		unique case (slope)
			TPW_SLOPE_SINGLE: ovf_evt = tick && at_top;
			TPW_SLOPE_DUAL: ovf_evt = tick && (dir_q == TPW_DIR_DOWN)
				&& (count_q == TPW_BOTTOM);
			default: ovf_evt = tick && (count_q == TPW_MAX);
		endcase
	end

	// ************************************************************
	// prescaler and channels
	// ************************************************************
	tpw_prescaler #(
		.DIV_W(TPW_DIV_W)
	) u_prescaler (
		.i_core_clk(i_core_clk),
		.i_srst(i_srst),
		.i_clk_sel(ctrl_q.clk_sel),
		.o_tick(tick)
	);

	tpw_channel u_chan_a (
		.i_core_clk(i_core_clk),
		.i_srst(i_srst),
		.i_tick(tick),
		.i_slope(slope),
		.i_dir(dir_q),
		.i_count(count_q),
		.i_top(top),
		.i_compare(cmp_act_a_q),
		.i_action(ctrl_q.act_a),
		.i_toggle_ok(tpw_top_is_cmpa(ctrl_q.mode)),
		.o_match(match_a),
		.o_oc(oc_a)
	);

	// channel b never toggles in pwm modes: its compare cannot define top
	tpw_channel u_chan_b (
		.i_core_clk(i_core_clk),
		.i_srst(i_srst),
		.i_tick(tick),
		.i_slope(slope),
		.i_dir(dir_q),
		.i_count(count_q),
		.i_top(top),
		.i_compare(cmp_act_b_q),
		.i_action(ctrl_q.act_b),
		.i_toggle_ok(1'b0),
		.o_match(match_b),
		.o_oc(oc_b)
	);

	// ************************************************************
	// counter and slope direction
	// ************************************************************
	always_ff @(posedge i_core_clk)
	begin
		if (i_srst)
		begin
			count_q <= TPW_RST_WORD;
			dir_q <= TPW_DIR_UP;
		end
		else if (wr_count)
			count_q <= i_wdata;
		else if (tick)
		begin
			unique case (slope)
				TPW_SLOPE_SINGLE:
				begin
					// a top below the count runs on through max and wraps
					count_q <= at_top ? TPW_BOTTOM : count_q + 16'h0001;
					dir_q <= TPW_DIR_UP;
				end
				TPW_SLOPE_DUAL:
				begin
					if (dir_q == TPW_DIR_UP)
					begin
						if (at_top)
						begin
							dir_q <= TPW_DIR_DOWN;
							count_q <= count_q - 16'h0001;
						end
						else
							count_q <= count_q + 16'h0001;
					end
					else if (count_q == TPW_BOTTOM)
					begin
						dir_q <= TPW_DIR_UP;
						count_q <= count_q + 16'h0001;
					end
					else
						count_q <= count_q - 16'h0001;
				end
				default:
				begin
					count_q <= count_q + 16'h0001;
					dir_q <= TPW_DIR_UP;
				end
			endcase
		end
	end

	// ************************************************************
	// software registers
	// ************************************************************
	// control: actions take effect at once, not buffered with compares
	always_ff @(posedge i_core_clk)
	begin
		if (i_srst)
			ctrl_q <= tpw_ctrl_t'(TPW_RST_WORD[10:0]);
		else if (wr_ctrl)
			ctrl_q <= tpw_ctrl_t'(i_wdata[10:0]);
	end

	// compare buffers take masked writes at any time
	always_ff @(posedge i_core_clk)
	begin
		if (i_srst)
		begin
			cmp_buf_a_q <= TPW_RST_WORD;
			cmp_buf_b_q <= TPW_RST_WORD;
		end
		else
		begin
			if (wr_cmp_a)
				cmp_buf_a_q <= i_wdata & wmask;
			if (wr_cmp_b)
				cmp_buf_b_q <= i_wdata & wmask;
		end
	end

	// active compares: buffered in pwm modes, straight through otherwise
	always_ff @(posedge i_core_clk)
	begin
		if (i_srst)
		begin
			cmp_act_a_q <= TPW_RST_WORD;
			cmp_act_b_q <= TPW_RST_WORD;
		end
		else if (slope == TPW_SLOPE_NONE || load_evt)
		begin
			cmp_act_a_q <= cmp_buf_a_q;
			cmp_act_b_q <= cmp_buf_b_q;
		end
	end

	// capture top has no buffer, so a write acts on the next compare
	always_ff @(posedge i_core_clk)
	begin
		if (i_srst)
			cap_top_q <= TPW_RST_WORD;
		else if (wr_cap)
			cap_top_q <= i_wdata;
	end

	always_ff @(posedge i_core_clk)
	begin
		if (i_srst)
			port_q <= tpw_port_t'(TPW_RST_WORD[3:0]);
		else if (wr_port)
			port_q <= tpw_port_t'(i_wdata[3:0]);
	end

	// ************************************************************
	// flags: write one to clear, a same cycle event still sets
	// ************************************************************
	always_comb
	begin
		flags_set.overflow = ovf_evt;
		flags_set.cmp_a = match_a;
		flags_set.cmp_b = match_b;
		flags_set.capture = load_evt && tpw_top_is_cap(ctrl_q.mode);
		flags_clr = wr_flags ? tpw_flags_t'(i_wdata[3:0]) : tpw_flags_t'(4'h0);
		flags_d = (flags_q & ~flags_clr) | flags_set;
	end

	always_ff @(posedge i_core_clk)
	begin
		if (i_srst)
			flags_q <= tpw_flags_t'(TPW_RST_WORD[3:0]);
		else
			flags_q <= flags_d;
	end

	// ************************************************************
	// read port: data only in the cycle after the strobe
	// ************************************************************
	always_comb
	begin
		rdata_d = '0;
		unique case (i_addr)
			TPW_OFS_CTRL: rdata_d = {5'h00, ctrl_q};
			TPW_OFS_COUNT: rdata_d = count_q;
			TPW_OFS_CMP_A: rdata_d = cmp_buf_a_q;
			TPW_OFS_CMP_B: rdata_d = cmp_buf_b_q;
			TPW_OFS_CAP_TOP: rdata_d = cap_top_q;
			TPW_OFS_FLAGS: rdata_d = {12'h000, flags_q};
			TPW_OFS_PORT: rdata_d = {12'h000, port_q};
			default: rdata_d = '0; // unmapped reads as zero
		endcase
	end

	always_ff @(posedge i_core_clk)
	begin
		if (i_srst || !i_rd)
			o_rdata <= '0;
		else
			o_rdata <= rdata_d;
	end

	// ************************************************************
	// pin drive: override port data, gated by direction
	// ************************************************************
	// one cycle behind the compare register so every output is a flop
	always_ff @(posedge i_core_clk)
	begin
		if (i_srst)
		begin
			o_pin_a <= 1'b0;
			o_pin_a_oe <= 1'b0;
			o_pin_b <= 1'b0;
			o_pin_b_oe <= 1'b0;
		end
		else
		begin
			o_pin_a <= port_q.dir_a
				&& ((ctrl_q.act_a != TPW_ACT_NONE) ? oc_a : port_q.data_a);
			o_pin_a_oe <= port_q.dir_a;
			o_pin_b <= port_q.dir_b
				&& ((ctrl_q.act_b != TPW_ACT_NONE) ? oc_b : port_q.data_b);
			o_pin_b_oe <= port_q.dir_b;
		end
	end

endmodule

// [inc/tpw_pkg.sv]
package tpw_pkg;

	// ************************************************************
	// register map, byte addresses
	// ************************************************************
	localparam int unsigned TPW_ADDR_W = 8;
	localparam int unsigned TPW_DATA_W = 16;
	localparam logic [7:0] TPW_OFS_CTRL = 8'h00;
	localparam logic [7:0] TPW_OFS_COUNT = 8'h04;
	localparam logic [7:0] TPW_OFS_CMP_A = 8'h08;
	localparam logic [7:0] TPW_OFS_CMP_B = 8'h0C;
	localparam logic [7:0] TPW_OFS_CAP_TOP = 8'h10;
	localparam logic [7:0] TPW_OFS_FLAGS = 8'h14;
	localparam logic [7:0] TPW_OFS_PORT = 8'h18;

	// ************************************************************
	// reset values and counter landmarks
	// ************************************************************
	localparam logic [15:0] TPW_RST_WORD = 16'h0000;
	localparam logic [15:0] TPW_BOTTOM = 16'h0000;
	localparam logic [15:0] TPW_MAX = 16'hFFFF;
	localparam logic [15:0] TPW_TOP_8 = 16'h00FF;
	localparam logic [15:0] TPW_TOP_9 = 16'h01FF;
	localparam logic [15:0] TPW_TOP_10 = 16'h03FF;

	// ************************************************************
	// waveform modes, output actions, prescaler selects
	// ************************************************************
	localparam logic [3:0] TPW_MODE_PC_8 = 4'h1;
	localparam logic [3:0] TPW_MODE_PC_9 = 4'h2;
	localparam logic [3:0] TPW_MODE_PC_10 = 4'h3;
	localparam logic [3:0] TPW_MODE_FAST_8 = 4'h5;
	localparam logic [3:0] TPW_MODE_FAST_9 = 4'h6;
	localparam logic [3:0] TPW_MODE_FAST_10 = 4'h7;
	localparam logic [3:0] TPW_MODE_PC_CAP = 4'hA;
	localparam logic [3:0] TPW_MODE_PC_CMPA = 4'hB;
	localparam logic [3:0] TPW_MODE_FAST_CAP = 4'hE;
	localparam logic [3:0] TPW_MODE_FAST_CMPA = 4'hF;
	localparam logic [1:0] TPW_ACT_NONE = 2'h0;
	localparam logic [1:0] TPW_ACT_TOGGLE = 2'h1;
	localparam logic [1:0] TPW_ACT_CLEAR = 2'h2;
	localparam logic [1:0] TPW_ACT_SET = 2'h3;
	localparam int unsigned TPW_DIV_W = 11;

	typedef enum logic [1:0] {
		TPW_SLOPE_NONE = 2'b00,
		TPW_SLOPE_SINGLE = 2'b01,
		TPW_SLOPE_DUAL = 2'b11
	} tpw_slope_t;

	typedef enum logic {
		TPW_DIR_UP = 1'b0,
		TPW_DIR_DOWN = 1'b1
	} tpw_dir_t;

	// control word layout, bit 0 upward: mode, action a, action b, clock select
	typedef struct packed {
		logic [2:0] clk_sel;
		logic [1:0] act_b;
		logic [1:0] act_a;
		logic [3:0] mode;
	} tpw_ctrl_t;

	typedef struct packed {
		logic capture;
		logic cmp_b;
		logic cmp_a;
		logic overflow;
	} tpw_flags_t;

	typedef struct packed {
		logic dir_b;
		logic dir_a;
		logic data_b;
		logic data_a;
	} tpw_port_t;

	// ************************************************************
	// mode decoding
	// ************************************************************
	function automatic tpw_slope_t tpw_slope(input logic [3:0] mode);
		unique case (mode)
			TPW_MODE_FAST_8, TPW_MODE_FAST_9, TPW_MODE_FAST_10,
			TPW_MODE_FAST_CAP, TPW_MODE_FAST_CMPA: tpw_slope = TPW_SLOPE_SINGLE;
			TPW_MODE_PC_8, TPW_MODE_PC_9, TPW_MODE_PC_10,
			TPW_MODE_PC_CAP, TPW_MODE_PC_CMPA: tpw_slope = TPW_SLOPE_DUAL;
			default: tpw_slope = TPW_SLOPE_NONE;
		endcase
	endfunction

	// fixed top, or zero when the mode has none
	function automatic logic [15:0] tpw_fixed_top(input logic [3:0] mode);
		unique case (mode)
			TPW_MODE_FAST_8, TPW_MODE_PC_8: tpw_fixed_top = TPW_TOP_8;
			TPW_MODE_FAST_9, TPW_MODE_PC_9: tpw_fixed_top = TPW_TOP_9;
			TPW_MODE_FAST_10, TPW_MODE_PC_10: tpw_fixed_top = TPW_TOP_10;
			default: tpw_fixed_top = TPW_BOTTOM;
		endcase
	endfunction

	function automatic logic tpw_top_is_cap(input logic [3:0] mode);
		tpw_top_is_cap = (mode == TPW_MODE_FAST_CAP) || (mode == TPW_MODE_PC_CAP);
	endfunction

	function automatic logic tpw_top_is_cmpa(input logic [3:0] mode);
		tpw_top_is_cmpa = (mode == TPW_MODE_FAST_CMPA) || (mode == TPW_MODE_PC_CMPA);
	endfunction

	function automatic logic [TPW_DIV_W-1:0] tpw_divisor(input logic [2:0] sel);
		unique case (sel)
			3'h1: tpw_divisor = 11'h001;
			3'h2: tpw_divisor = 11'h008;
			3'h3: tpw_divisor = 11'h040;
			3'h4: tpw_divisor = 11'h100;
			3'h5: tpw_divisor = 11'h400;
			default: tpw_divisor = 11'h000;
		endcase
	endfunction

endpackage

// [verilog/tpw_prescaler.sv]
`timescale 1ns/1ps
module tpw_prescaler
	import tpw_pkg::*;
#(
	parameter int unsigned DIV_W = TPW_DIV_W
)
(
	input wire logic i_core_clk,
	input wire logic i_srst,
	input wire logic [2:0] i_clk_sel,
	output logic o_tick
);

	logic [DIV_W-1:0] div_q;
	logic [DIV_W-1:0] limit;

	if (DIV_W < TPW_DIV_W)
	begin : g_chk
		$error("prescaler counter too narrow for divide by 1024");
	end

	// terminal count; select zero stops the timer
	assign limit = DIV_W'(tpw_divisor(i_clk_sel) - 11'h001);

	// ************************************************************
	// divider, one tick pulse per period
	// ************************************************************
	always_ff @(posedge i_core_clk)
	begin
		if (i_srst || i_clk_sel == 3'h0 || i_clk_sel > 3'h5)
		begin
			div_q <= '0;
			o_tick <= 1'b0;
		end
		else if (div_q >= limit)
		begin
			div_q <= '0;
			o_tick <= 1'b1;
		end
		else
		begin
			div_q <= div_q + DIV_W'(1);
			o_tick <= 1'b0;
		end
	end

endmodule

// [verilog/tpw_channel.sv]
`timescale 1ns/1ps
module tpw_channel
	import tpw_pkg::*;
(
	input wire logic i_core_clk,
	input wire logic i_srst,
	input wire logic i_tick,
	input wire tpw_slope_t i_slope,
	input wire tpw_dir_t i_dir,
	input wire logic [15:0] i_count,
	input wire logic [15:0] i_top,
	input wire logic [15:0] i_compare,
	input wire logic [1:0] i_action,
	input wire logic i_toggle_ok,
	output logic o_match,
	output logic o_oc
);

	logic inv;

	// match only counts on a timer tick
	assign o_match = i_tick && (i_count == i_compare);
	assign inv = (i_action == TPW_ACT_SET);

	// ************************************************************
	// compare output register
	// ************************************************************
	always_ff @(posedge i_core_clk)
	begin
		if (i_srst)
			o_oc <= 1'b0;
		else if (i_tick && i_action != TPW_ACT_NONE)
		begin
			unique case (i_slope)
				TPW_SLOPE_SINGLE:
				begin
					// bottom wins over a match at top: compare equal top is constant
					if (i_action == TPW_ACT_TOGGLE)
					begin
						if (i_toggle_ok && o_match)
							o_oc <= ~o_oc;
					end
					else if (i_count == i_top)
						o_oc <= ~inv;
					else if (o_match)
						o_oc <= inv;
				end
				TPW_SLOPE_DUAL:
				begin
					if (i_action == TPW_ACT_TOGGLE)
					begin
						if (i_toggle_ok && o_match)
							o_oc <= ~o_oc;
					end
					else if (i_compare == TPW_BOTTOM)
						o_oc <= inv;
					else if (i_compare == i_top)
						o_oc <= ~inv;
					else if (o_match)
						o_oc <= (i_dir == TPW_DIR_UP) ? inv : ~inv;
				end
				default:
				begin
					// plain match actions outside the pwm modes
					if (o_match)
						o_oc <= (i_action == TPW_ACT_TOGGLE) ? ~o_oc : inv;
				end
			endcase
		end
	end

endmodule

// [testbench/tpw_top_asserts.sv]
`timescale 1ns/1ps
module tpw_top_asserts
	import tpw_pkg::*;
#(
	parameter int unsigned CNT_W = 16
)
(
	input wire logic i_core_clk,
	input wire logic i_srst,
	input wire logic [TPW_ADDR_W-1:0] i_addr,
	input wire logic [TPW_DATA_W-1:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [TPW_DATA_W-1:0] o_rdata,
	input wire logic o_pin_a,
	input wire logic o_pin_a_oe,
	input wire logic o_pin_b,
	input wire logic o_pin_b_oe
);
	tpw_ctrl_t ctrl_q;
	tpw_port_t port_q;
	logic [15:0] cmpa_q;
	logic [15:0] cap_q;
	logic [15:0] mask_w;
	logic stop_w;
	logic pa_w;
	logic pb_w;

	// ************************************************************
	// shadow of software writes
	// ************************************************************
	// masks follow the mode already in effect, as the design does
	always_comb
	begin
		case (ctrl_q.mode)
			4'h1, 4'h5: mask_w = TPW_TOP_8;
			4'h2, 4'h6: mask_w = TPW_TOP_9;
			4'h3, 4'h7: mask_w = TPW_TOP_10;
			default: mask_w = TPW_MAX;
		endcase
	end
	assign stop_w = (ctrl_q.clk_sel == 3'h0) || (ctrl_q.clk_sel > 3'h5);
	assign pa_w = port_q.dir_a & port_q.data_a;
	assign pb_w = port_q.dir_b & port_q.data_b;

	always_ff @(posedge i_core_clk)
	begin
		if (i_srst)
		begin
			ctrl_q <= '0;
			port_q <= '0;
			cmpa_q <= 16'h0000;
			cap_q <= 16'h0000;
		end
		else if (i_wr)
		begin
			if (i_addr == TPW_OFS_CTRL)
				ctrl_q <= i_wdata[10:0];
			if (i_addr == TPW_OFS_PORT)
				port_q <= i_wdata[3:0];
			if (i_addr == TPW_OFS_CMP_A)
				cmpa_q <= i_wdata & mask_w;
			if (i_addr == TPW_OFS_CAP_TOP)
				cap_q <= i_wdata;
		end
	end

	// ************************************************************
	// properties
	// ************************************************************
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (i_srst);

	// stopped timer and a silent bus; four cycles cover a late tick
	sequence s_quiet;
		(stop_w && !i_wr)[*4];
	endsequence

	property p_rst_clear;
		$past(i_srst) |-> !o_pin_a && !o_pin_b && !o_pin_a_oe && !o_pin_b_oe && o_rdata == 16'h0000;
	endproperty
	property p_oe;
		!$past(i_srst) |-> o_pin_a_oe == $past(port_q.dir_a) && o_pin_b_oe == $past(port_q.dir_b);
	endproperty
	property p_pin_off;
		(o_pin_a_oe || !o_pin_a) && (o_pin_b_oe || !o_pin_b);
	endproperty
	property p_pass_a;
		!$past(i_srst) && $past(ctrl_q.act_a) == TPW_ACT_NONE |-> o_pin_a == $past(pa_w);
	endproperty
	property p_pass_b;
		!$past(i_srst) && $past(ctrl_q.act_b) == TPW_ACT_NONE |-> o_pin_b == $past(pb_w);
	endproperty
	property p_stop_hold;
		s_quiet |-> $stable(o_pin_a) && $stable(o_pin_b);
	endproperty
	property p_cmpa_read;
		!$past(i_srst) && $past(i_rd) && $past(i_addr) == TPW_OFS_CMP_A |-> o_rdata == $past(cmpa_q);
	endproperty
	property p_cap_read;
		!$past(i_srst) && $past(i_rd) && $past(i_addr) == TPW_OFS_CAP_TOP |-> o_rdata == $past(cap_q);
	endproperty

	a_rst_clear: assert property (p_rst_clear)
		else $error("outputs not cleared by reset");
	a_oe: assert property (p_oe)
		else $error("output enable differs from direction bit");
	a_pin_off: assert property (p_pin_off)
		else $error("pin driven high while not an output");
	a_pass_a: assert property (p_pass_a)
		else $error("pin a not port data with action zero");
	a_pass_b: assert property (p_pass_b)
		else $error("pin b not port data with action zero");
	a_stop_hold: assert property (p_stop_hold)
		else $error("pin moved while timer stopped");
	a_cmpa_read: assert property (p_cmpa_read)
		else $error("compare a readback not masked write");
	a_cap_read: assert property (p_cap_read)
		else $error("capture top readback differs");
endmodule

bind tpw_top tpw_top_asserts #(.CNT_W(CNT_W)) u_asserts (.i_core_clk(i_core_clk), .i_srst(i_srst),
	.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
	.o_pin_a(o_pin_a), .o_pin_a_oe(o_pin_a_oe), .o_pin_b(o_pin_b), .o_pin_b_oe(o_pin_b_oe));

// [testbench/testbench.sv]
`timescale 1ns/1ps
module testbench;
	import tpw_pkg::*;
	logic i_core_clk = 1'b0;
	logic i_srst = 1'b1;
	logic [7:0] i_addr = 8'h00;
	logic [15:0] i_wdata = 16'h0000;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic [15:0] o_rdata;
	logic o_pin_a, o_pin_a_oe, o_pin_b, o_pin_b_oe;
	int error_cnt = 0;
	int compares = 0;
	int seed = 12681;
	logic [15:0] smp [0:2100];

	always #25 i_core_clk = ~i_core_clk;

	tpw_top #(.CNT_W(16)) u_dut (.i_core_clk(i_core_clk), .i_srst(i_srst), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_pin_a(o_pin_a),
		.o_pin_a_oe(o_pin_a_oe), .o_pin_b(o_pin_b), .o_pin_b_oe(o_pin_b_oe));

	// ************************************************************
	// bus, reset and report tasks
	// ************************************************************
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic stop_test;
		$display("errors=%0d compares=%0d", error_cnt, compares);
		if (error_cnt == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic do_reset;
		i_srst <= 1'b1;
		repeat (2) @(posedge i_core_clk);
		i_srst <= 1'b0;
		@(posedge i_core_clk);
	endtask

	// a spare edge after each access keeps strobes from being assigned twice at once
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_core_clk);
		i_wr <= 1'b0;
		@(posedge i_core_clk);
	endtask

	// back-to-back reads, one sample per edge
	task automatic rd_burst(input logic [7:0] a, input int n);
		i_addr <= a;
		i_rd <= 1'b1;
		for (int k = 0; k < n; k++)
		begin
			@(posedge i_core_clk);
			if (k == n - 1)
				i_rd <= 1'b0;
			#1 smp[k] = o_rdata;
		end
		@(posedge i_core_clk);
	endtask

	task automatic cfg(input logic [3:0] m, input logic [1:0] aa, input logic [1:0] ab,
		input logic [2:0] s, input logic [15:0] cnt, input logic [15:0] ca, input logic [15:0] cb);
		wr(TPW_OFS_CTRL, 16'h0000);
		wr(TPW_OFS_CMP_A, ca);
		wr(TPW_OFS_CMP_B, cb);
		wr(TPW_OFS_CAP_TOP, 16'h0009);
		wr(TPW_OFS_COUNT, cnt);
		wr(TPW_OFS_CTRL, {5'h00, s, ab, aa, m});
	endtask

	// ************************************************************
	// expectations
	// ************************************************************
	function automatic logic [15:0] msk(input logic [3:0] m);
		case (m)
			4'h1, 4'h5: msk = 16'h00FF;
			4'h2, 4'h6: msk = 16'h01FF;
			4'h3, 4'h7: msk = 16'h03FF;
			default: msk = 16'hFFFF;
		endcase
	endfunction

	// high cycles in 180 cycles, top 9: eighteen fast periods, ten dual ones
	function automatic int hi(input logic dual, input logic [1:0] act, input int c,
		input logic dat, input logic dir);
		if (!dir)
			return 0;
		case (act)
			2'h0: return dat ? 180 : 0;
			2'h1: return 90;
			2'h2: return dual ? 20 * c : 18 * (c + 1);
			default: return dual ? 180 - 20 * c : 18 * (9 - c);
		endcase
	endfunction

	// walks the sampled counter; top1 takes over once top0 is reached
	task automatic chk_seq(input int n, input logic [15:0] top0, input logic [15:0] top1,
		input logic dual);
		logic [15:0] top;
		logic dn;
		logic [15:0] e;
		top = top0;
		dn = 1'b0;
		for (int k = 1; k < n; k++)
		begin
			if (!dual)
				e = (smp[k-1] == top) ? 16'h0000 : smp[k-1] + 16'h0001;
			else if (smp[k-1] == top)
			begin
				e = smp[k-1] - 16'h0001;
				dn = 1'b1;
			end
			else if (smp[k-1] == 16'h0000)
			begin
				e = 16'h0001;
				dn = 1'b0;
			end
			else
				e = dn ? smp[k-1] - 16'h0001 : smp[k-1] + 16'h0001;
			if (smp[k-1] == top)
				top = top1;
			chk(smp[k], e);
		end
	endtask

	// ************************************************************
	// main sequence
	// ************************************************************
	initial
	begin
		logic [3:0] md [10];
		int dv [8];
		logic [1:0] acts [3];
		logic [3:0] m;
		logic [3:0] pt;
		logic [15:0] t0;
		logic [15:0] t1;
		logic [15:0] d;
		logic [1:0] aa;
		logic [1:0] ab;
		int ha;
		int hb;
		int n;
		int ca;
		int cb;
		md = '{4'h5, 4'h6, 4'h7, 4'hE, 4'hF, 4'h1, 4'h2, 4'h3, 4'hA, 4'hB};
		dv = '{8, 1, 8, 64, 256, 1024, 8, 8};
		acts = '{2'h0, 2'h2, 2'h3};
		do_reset();
		for (int i = 0; i < 8; i++)
		begin
			rd_burst(8'(4 * i), 1);
			chk(smp[0], TPW_RST_WORD);
		end
		for (int i = 0; i < 10; i++)
		begin
			d = 16'($random(seed));
			wr(TPW_OFS_CTRL, {12'h000, md[i]});
			wr(TPW_OFS_CMP_A, d);
			wr(TPW_OFS_CMP_B, ~d);
			rd_burst(TPW_OFS_CMP_A, 1);
			chk(smp[0], d & msk(md[i]));
			rd_burst(TPW_OFS_CMP_B, 1);
			chk(smp[0], ~d & msk(md[i]));
			wr(TPW_OFS_CAP_TOP, d);
			rd_burst(TPW_OFS_CAP_TOP, 1);
			chk(smp[0], d);
		end
		// counter walks; in mode 14 the count starts far above capture top to force the wrap
		for (int i = 0; i < 10; i++)
		begin
			m = md[i];
			t0 = !m[3] ? msk(m) : (m[0] ? 16'h000B : 16'h0009);
			do_reset();
			cfg(m, 2'h0, 2'h0, 3'h1, !m[3] ? t0 - 16'h0003 : (m == 4'hE ? 16'hFFF0 : 16'h0000),
				16'h000B, 16'h0003);
			t1 = t0;
			if (m[3] && m[0])
			begin
				wr(TPW_OFS_CMP_A, 16'h000F);
				t1 = 16'h000F;
			end
			rd_burst(TPW_OFS_COUNT, 40);
			chk_seq(40, t0, t1, !m[2]);
		end
		// plain mode: counts on through max and wraps to zero
		cfg(4'h0, 2'h0, 2'h0, 3'h1, 16'hFFFD, 16'h0000, 16'h0000);
		rd_burst(TPW_OFS_COUNT, 8);
		chk_seq(8, TPW_MAX, TPW_MAX, 1'b0);
		// every clock select: two ticks in two divider periods, none when stopped
		for (int s = 0; s < 8; s++)
		begin
			cfg(4'h5, 2'h0, 2'h0, 3'(s), 16'h0000, 16'h0000, 16'h0000);
			n = 2 * dv[s] + 1;
			rd_burst(TPW_OFS_COUNT, n);
			ha = 0;
			for (int k = 1; k < n; k++)
				ha += (smp[k] !== smp[k-1]);
			chk(16'(ha), (s == 0 || s > 5) ? 16'h0000 : 16'h0002);
		end
		// compare b above top must never flag
		for (int i = 0; i < 2; i++)
		begin
			cfg(i ? 4'hA : 4'hE, 2'h0, 2'h0, 3'h1, 16'h0000, 16'h0005, 16'h0020);
			wr(TPW_OFS_FLAGS, 16'h000F);
			repeat (40) @(posedge i_core_clk);
			rd_burst(TPW_OFS_FLAGS, 1);
			chk(smp[0], 16'h000B);
		end
		// duty cycles at the pins; first four runs are the extreme compares
		for (int it = 0; it < 10; it++)
		begin
			m = (it < 8) ? (it[0] ? 4'hA : 4'hE) : (it[0] ? 4'hB : 4'hF);
			ca = (it < 2) ? 0 : (it < 8 && it >= 4) ? $unsigned($random(seed)) % 10 : 9;
			cb = (it < 2) ? 9 : (it < 4) ? 0 : $unsigned($random(seed)) % 10;
			aa = (it < 4) ? 2'h3 : (it < 8) ? acts[$unsigned($random(seed)) % 3] : 2'h1;
			ab = (it < 4) ? 2'h2 : acts[$unsigned($random(seed)) % 3];
			pt = 4'($random(seed));
			if (it < 4 || it >= 8)
				pt[3:2] = 2'b11;
			wr(TPW_OFS_PORT, {12'h000, pt});
			cfg(m, aa, ab, 3'h1, 16'h0000, 16'(ca), 16'(cb));
			repeat (40) @(posedge i_core_clk);
			ha = 0;
			hb = 0;
			repeat (180)
			begin
				@(negedge i_core_clk);
				ha += o_pin_a;
				hb += o_pin_b;
			end
			@(posedge i_core_clk);
			chk(16'(ha), 16'(hi(!m[2], aa, ca, pt[0], pt[2])));
			chk(16'(hb), 16'(hi(!m[2], ab, cb, pt[1], pt[3])));
		end
		stop_test();
	end

	// hang guard
	initial
	begin
		repeat (60000) @(posedge i_core_clk);
		error_cnt++;
		stop_test();
	end
endmodule
